/* File: hdl/tmr_timer8.sv */
// Purpose: Single channel 8-bit timer/counter with compare output and flags.
// Assumes: All inputs synchronous to clk; crystal input already squared up.
// Notes: Register reads return data one cycle after the read strobe.
`timescale 1ns/10ps
`default_nettype none
module tmr_timer8
  import tmr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [DATA_W-1:0] rdData,
  input wire logic crystal_in_pin,
  output logic crystal_out_pin,
  output logic compare_output_pin,
  output logic compareOutEn,
  output logic irq
);

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  logic [7:0] count_value_reg;
  logic [7:0] count_value_next;
  logic [7:0] compare_value_reg;
  logic [7:0] compareActive_reg;
  logic [7:0] compareActive_next;
  logic [6:0] control_reg;
  logic [7:0] async_clock_status_reg;
  logic [1:0] shared_timer_flag_reg;
  logic [1:0] shared_timer_flag_next;
  logic [1:0] shared_timer_mask_reg;
  logic [DATA_W-1:0] rdData_reg;
  logic countDown_reg;
  logic countDown_next;
  logic matchBlock_reg;
  logic waveOut_reg;
  logic waveOut_next;
  logic xtalPrev_reg;
  logic xtalOut_reg;

  wire cntWr = wrStrobe && (addr == OFF_COUNT);
  wire cmpWr = wrStrobe && (addr == OFF_COMPARE);
  wire ctlWr = wrStrobe && (addr == OFF_CONTROL);
  wire asyWr = wrStrobe && (addr == OFF_ASYNC);
  wire clrWr = wrStrobe && (addr == OFF_FLAG_CLR);
  wire mskWr = wrStrobe && (addr == OFF_MASK);

  // ----------------------------------------------------------------
  // Control fields and clock source
  // ----------------------------------------------------------------
  // Field slices; the force bit is a strobe and is never stored.
  wire [2:0] clkSel = control_reg[CTL_CS_LSB +: 3];
  tmr_mode_t mode;
  tmr_com_t com;
  assign mode = tmr_mode_t'(control_reg[CTL_MODE_LSB +: 2]);
  assign com = tmr_com_t'(control_reg[CTL_COM_LSB +: 2]);
  wire pwmMode = (mode == MODE_FAST_PWM) || (mode == MODE_PHASE_PWM);
  wire asyncSel = async_clock_status_reg[ASYNC_SEL_BIT];

  // The crystal input is sampled on clk, so its rate must stay well below clk/2.
  wire xtalEdge = crystal_in_pin && !xtalPrev_reg;
  // Default is one source tick per clk; the crystal replaces it when selected.
  wire srcTick = asyncSel ? xtalEdge : 1'b1;
  wire tick;

  tmr_prescaler #(
    .PW(PRE_W)
  ) uPrescaler (
    .clk(clk),
    .rst_n(rst_n),
    .srcTick(srcTick),
    .restart(asyWr),
    .clkSel(clkSel),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Counter unit
  // ----------------------------------------------------------------
  wire atBottom = (count_value_reg == BOTTOM_VAL);
  wire atMax = (count_value_reg == MAX_VAL);
  wire match = (count_value_reg == compareActive_reg);
  // Top is the compare value in clear-on-compare mode, else the maximum.
  wire [7:0] topVal = (mode == MODE_CTC) ? compareActive_reg : MAX_VAL;
  wire atTop = (count_value_reg == topVal);
  wire [7:0] countUp = count_value_reg + 8'h01;
  wire [7:0] countDn = count_value_reg - 8'h01;
  // A count write suppresses the match seen at the following tick.
  wire realMatch = tick && match && !matchBlock_reg;
  wire phaseTurnUp = countDown_reg && atBottom;
  wire phaseTurnDn = !countDown_reg && atMax;

  // Next count; a software write overrides any count or clear.
  assign countDown_next = (mode != MODE_PHASE_PWM) ? 1'b0 :
                          (tick && phaseTurnDn) ? 1'b1 :
                          (tick && phaseTurnUp) ? 1'b0 : countDown_reg;
  assign count_value_next = cntWr ? wrData :
                            !tick ? count_value_reg :
                            (mode == MODE_CTC && atTop) ? BOTTOM_VAL :
                            (mode == MODE_PHASE_PWM && countDown_next) ? countDn :
                            countUp;

  // Overflow: at maximum in single slope modes, at bottom in phase correct.
  wire ovfEvent = tick && ((mode == MODE_PHASE_PWM) ? phaseTurnUp : atMax);
  wire cmpEvent = realMatch;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_value_reg <= RST_COUNT;
      countDown_reg <= 1'b0;
      matchBlock_reg <= 1'b0;
    end
    else
    begin
      count_value_reg <= count_value_next;
      countDown_reg <= countDown_next;
      matchBlock_reg <= cntWr ? 1'b1 : (tick ? 1'b0 : matchBlock_reg);
    end
  end

  // ----------------------------------------------------------------
  // Compare buffer
  // ----------------------------------------------------------------
  // Double buffering in PWM modes avoids odd-length pulses; the active
  // value only moves at the top of the sequence.
  assign compareActive_next = (cmpWr && !pwmMode) ? wrData :
                              (pwmMode && tick && atMax) ? compare_value_reg :
                              compareActive_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      compare_value_reg <= RST_COMPARE;
      compareActive_reg <= RST_COMPARE;
    end
    else
    begin
      compare_value_reg <= cmpWr ? wrData : compare_value_reg;
      compareActive_reg <= compareActive_next;
    end
  end

  // ----------------------------------------------------------------
  // Waveform generator
  // ----------------------------------------------------------------
  // Force acts only outside PWM and never touches flags or count.
  wire forceMatch = ctlWr && wrData[CTL_FORCE_BIT] && !pwmMode;
  wire nonPwmHit = (realMatch || forceMatch) && !pwmMode;
  wire upMatch = realMatch && !countDown_next;
  wire fastBottom = (mode == MODE_FAST_PWM) && tick && atMax;
  wire wasteCom = com[1];
  // Compare output mode is not buffered, so a change acts at once.
  assign waveOut_next = (nonPwmHit && com == COM_TOGGLE) ? !waveOut_reg :
                        (nonPwmHit && com == COM_CLEAR) ? 1'b0 :
                        (nonPwmHit && com == COM_SET) ? 1'b1 :
                        (fastBottom && wasteCom) ? (com == COM_CLEAR) :
                        (mode == MODE_FAST_PWM && realMatch && wasteCom) ? (com == COM_SET) :
                        (mode == MODE_PHASE_PWM && realMatch && wasteCom) ?
                          ((com == COM_SET) ^ !upMatch) :
                        waveOut_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      waveOut_reg <= 1'b0;
    else
      waveOut_reg <= waveOut_next;
  end

  assign compare_output_pin = waveOut_reg;
  assign compareOutEn = (com != COM_OFF);

  // ----------------------------------------------------------------
  // Flags, mask and interrupt
  // ----------------------------------------------------------------
  // A new event in the same cycle as its clear keeps the flag set.
  wire [1:0] flagSet = {cmpEvent, ovfEvent};
  wire [1:0] flagClr = clrWr ? wrData[1:0] : 2'h0;
  assign shared_timer_flag_next = (shared_timer_flag_reg & ~flagClr) | flagSet;
  assign irq = |(shared_timer_flag_reg & shared_timer_mask_reg);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shared_timer_flag_reg <= RST_FLAG;
      shared_timer_mask_reg <= RST_MASK;
      control_reg <= RST_CONTROL;
      async_clock_status_reg <= RST_ASYNC;
    end
    else
    begin
      shared_timer_flag_reg <= shared_timer_flag_next;
      shared_timer_mask_reg <= mskWr ? wrData[1:0] : shared_timer_mask_reg;
      control_reg <= ctlWr ? wrData[6:0] : control_reg;
      async_clock_status_reg <= asyWr ? {7'h00, wrData[ASYNC_SEL_BIT]} :
                                async_clock_status_reg;
    end
  end

  // ----------------------------------------------------------------
  // Crystal pins and read port
  // ----------------------------------------------------------------
  // Inverted feedback toward the crystal, idle low when not selected.
  wire [DATA_W-1:0] rdMux = (addr == OFF_COUNT) ? count_value_reg :
                            (addr == OFF_COMPARE) ? compare_value_reg :
                            (addr == OFF_CONTROL) ? {1'b0, control_reg} :
                            (addr == OFF_ASYNC) ? async_clock_status_reg :
                            (addr == OFF_FLAG) ? {6'h00, shared_timer_flag_reg} :
                            (addr == OFF_MASK) ? {6'h00, shared_timer_mask_reg} :
                            8'h00;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xtalPrev_reg <= 1'b0;
      xtalOut_reg <= 1'b0;
      rdData_reg <= 8'h00;
    end
    else
    begin
      xtalPrev_reg <= crystal_in_pin;
      xtalOut_reg <= asyncSel && !crystal_in_pin;
      rdData_reg <= rdStrobe ? rdMux : 8'h00;
    end
  end

  assign crystal_out_pin = xtalOut_reg;
  assign rdData = rdData_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_STOPPED: assert property ((clkSel == 3'h0) && !cntWr |=> $stable(count_value_reg))
    else $error("Counter moved with no clock source selected.");

  AST_NORMAL_WRAP: assert property (
    (mode == MODE_NORMAL) && tick && atMax && !cntWr |=> count_value_reg == 8'h00)
    else $error("Normal mode did not wrap from maximum to zero.");

  AST_SYNC_STEP: assert property (
    !asyncSel && (clkSel == 3'h1) && (mode == MODE_NORMAL) && !cntWr && !asyWr
    |=> count_value_reg == $past(count_value_reg) + 8'h01)
    else $error("Undivided I/O clock did not advance the count each cycle.");

  AST_XTAL_HOLD: assert property (
    asyncSel && (clkSel == 3'h1) && !xtalEdge && !cntWr |=> $stable(count_value_reg))
    else $error("Count moved without a crystal edge in async mode.");

  AST_CTC_CLEAR: assert property (
    (mode == MODE_CTC) && tick && match && !cntWr |=> count_value_reg == 8'h00)
    else $error("Clear-on-compare did not restart from zero.");

  AST_CMP_FLAG: assert property (
    tick && match && !matchBlock_reg |=> shared_timer_flag_reg[FLAG_CMP_BIT])
    else $error("Compare match did not set the compare flag.");

  AST_OVF_FLAG: assert property (
    (mode == MODE_NORMAL) && tick && atMax |=> shared_timer_flag_reg[FLAG_OVF_BIT])
    else $error("Overflow did not set the overflow flag.");

  AST_WRITE_BLOCK: assert property (
    cntWr ##1 (tick && !cntWr) |=> !$rose(shared_timer_flag_reg[FLAG_CMP_BIT]))
    else $error("Compare flag set on the tick after a count write.");

  AST_PWM_BUFFER: assert property (
    pwmMode && cmpWr && !(tick && atMax) |=> $stable(compareActive_reg))
    else $error("PWM compare value changed away from the top.");

  // Outside PWM a compare write must reach the comparator at once.
  AST_COMPARE_DIRECT: assert property (
    !pwmMode && cmpWr |=> compareActive_reg == $past(wrData))
    else $error("Non-PWM compare write did not reach the comparator.");

  AST_IRQ_GATE: assert property (
    cmpEvent && shared_timer_mask_reg[FLAG_CMP_BIT] && !mskWr |=> irq)
    else $error("Unmasked compare flag did not raise the interrupt.");

  // A clear that meets a new event must lose, or an overflow would vanish.
  AST_SET_WINS: assert property (
    ovfEvent && clrWr && wrData[FLAG_OVF_BIT] |=> shared_timer_flag_reg[FLAG_OVF_BIT])
    else $error("Overflow flag lost to a clear in the same cycle.");

  AST_PHASE_TURN: assert property (
    (mode == MODE_PHASE_PWM) && tick && atMax && !cntWr ##1 (mode == MODE_PHASE_PWM)
    |-> count_value_reg == 8'hFE)
    else $error("Phase correct mode did not turn down at maximum.");

  AST_PHASE_BOTTOM: assert property (
    (mode == MODE_PHASE_PWM) && tick && countDown_reg && atBottom && !cntWr
    |=> shared_timer_flag_reg[FLAG_OVF_BIT] && (count_value_reg == 8'h01))
    else $error("Phase correct mode did not turn up and flag overflow at bottom.");

  // Forcing a compare drives the pin only; the flag must stay quiet.
  AST_FORCE_QUIET: assert property (
    forceMatch && !realMatch && !shared_timer_flag_reg[FLAG_CMP_BIT]
    |=> !shared_timer_flag_reg[FLAG_CMP_BIT])
    else $error("Forced compare set the compare flag.");

  AST_XTAL_IDLE: assert property (!asyncSel && !asyWr |=> !crystal_out_pin)
    else $error("Crystal feedback driven while the I/O clock is selected.");

  // The read answer stands for one cycle per strobe cycle and is zero otherwise.
  AST_READ_IDLE: assert property (!rdStrobe |=> rdData == 8'h00)
    else $error("Read data did not return to zero after the read cycle.");

  AST_READ_COUNT: assert property (
    rdStrobe && (addr == OFF_COUNT) |=> rdData == $past(count_value_reg))
    else $error("Count read did not return the count of the strobe cycle.");

  COV_OVERFLOW: cover property (ovfEvent && shared_timer_mask_reg[FLAG_OVF_BIT]);
  COV_CTC_MATCH: cover property ((mode == MODE_CTC) && cmpEvent);
  COV_PHASE_DOWN: cover property ((mode == MODE_PHASE_PWM) && countDown_reg && tick);
  COV_ASYNC_COUNT: cover property (asyncSel && tick);

endmodule
`default_nettype wire

/* File: hdl/tmr_pkg.sv */
// Purpose: Shared constants and types for the 8-bit timer/counter block.
// Assumes: 8-bit register port with one-cycle strobes.
// Notes: All offsets are byte addresses on the plain register port.
package tmr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFF_COUNT = 8'h00;
  localparam logic [7:0] OFF_COMPARE = 8'h01;
  localparam logic [7:0] OFF_CONTROL = 8'h02;
  localparam logic [7:0] OFF_ASYNC = 8'h03;
  localparam logic [7:0] OFF_FLAG = 8'h04;
  localparam logic [7:0] OFF_FLAG_CLR = 8'h05;
  localparam logic [7:0] OFF_MASK = 8'h06;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTL_CS_LSB = 0;
  localparam int CTL_MODE_LSB = 3;
  localparam int CTL_COM_LSB = 5;
  localparam int CTL_FORCE_BIT = 7;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_BIT = 1;
  localparam int ASYNC_SEL_BIT = 0;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_COMPARE = 8'h00;
  localparam logic [6:0] RST_CONTROL = 7'h00;
  localparam logic [7:0] RST_ASYNC = 8'h00;
  localparam logic [1:0] RST_FLAG = 2'h0;
  localparam logic [1:0] RST_MASK = 2'h0;

  // ----------------------------------------------------------------
  // Count limits and prescaler taps
  // ----------------------------------------------------------------
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  localparam logic [7:0] MAX_VAL = 8'hFF;
  localparam int PRE_W = 10;
  localparam logic [9:0] TAP_DIV1 = 10'h000;
  localparam logic [9:0] TAP_DIV8 = 10'h007;
  localparam logic [9:0] TAP_DIV32 = 10'h01F;
  localparam logic [9:0] TAP_DIV64 = 10'h03F;
  localparam logic [9:0] TAP_DIV128 = 10'h07F;
  localparam logic [9:0] TAP_DIV256 = 10'h0FF;
  localparam logic [9:0] TAP_DIV1024 = 10'h3FF;

  // Counting sequence and compare output behaviour.
  typedef enum logic [1:0] {MODE_NORMAL, MODE_PHASE_PWM, MODE_CTC, MODE_FAST_PWM} tmr_mode_t;
  typedef enum logic [1:0] {COM_OFF, COM_TOGGLE, COM_CLEAR, COM_SET} tmr_com_t;

endpackage

/* File: hdl/tmr_prescaler.sv */
// Purpose: Ten-bit prescaler that turns source ticks into timer ticks.
// Assumes: srcTick is a one-cycle pulse per source clock period.
// Notes: Select code zero gives no tick at all.
`timescale 1ns/10ps
`default_nettype none
module tmr_prescaler
  import tmr_pkg::*;
#(
  parameter int PW = PRE_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic srcTick,
  input wire logic restart,
  input wire logic [2:0] clkSel,
  output logic tick
);

  // ----------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------
  logic [PW-1:0] preCnt_reg;
  logic [PW-1:0] preCnt_next;
  logic [PW-1:0] tapMask;

  // Restart keeps the first period full length after a source change.
  assign preCnt_next = restart ? '0 : (srcTick ? preCnt_reg + PW'(1) : preCnt_reg);

  // Tap selection; each divider fires when its low bits are all ones.
  assign tapMask = (clkSel == 3'h2) ? PW'(TAP_DIV8) :
                   (clkSel == 3'h3) ? PW'(TAP_DIV32) :
                   (clkSel == 3'h4) ? PW'(TAP_DIV64) :
                   (clkSel == 3'h5) ? PW'(TAP_DIV128) :
                   (clkSel == 3'h6) ? PW'(TAP_DIV256) :
                   (clkSel == 3'h7) ? PW'(TAP_DIV1024) : PW'(TAP_DIV1);
  assign tick = (clkSel != 3'h0) && srcTick && !restart && ((preCnt_reg & tapMask) == tapMask);

  // Free running counter.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      preCnt_reg <= '0;
    else
      preCnt_reg <= preCnt_next;
  end

endmodule
`default_nettype wire

/* File: testbench/test_tmr_timer8.sv */
// Purpose: Self-checking bench for the 8-bit timer/counter over its register port.
// Assumes: Register reads return data in the cycle after the read strobe.
// Notes: Count values are judged to the exact tick, reckoned from the write that lands each step.
`timescale 1ns/10ps
`default_nettype none
module test_tmr_timer8;
  import tmr_pkg::*;

  logic clk;
  logic rst_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wrData;
  logic wrStrobe;
  logic rdStrobe;
  logic [DATA_W-1:0] rdData;
  logic crystalIn;
  logic crystalOut;
  logic cmpPin;
  logic cmpOutEn;
  logic irq;
  int n_fail;
  int n_compared;
  int cycles = 0;

  tmr_timer8 dut (
    .clk(clk),
    .rst_n(rst_n),
    .addr(addr),
    .wrData(wrData),
    .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe),
    .rdData(rdData),
    .crystal_in_pin(crystalIn),
    .crystal_out_pin(crystalOut),
    .compare_output_pin(cmpPin),
    .compareOutEn(cmpOutEn),
    .irq(irq)
  );

  // ----------------------------------------------------------------
  // Clock, cycle counter and hang guard
  // ----------------------------------------------------------------
  // The ceiling sits far above the fewer than nine hundred cycles the tests need.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail = n_fail + 1;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Register port and compare helpers
  // ----------------------------------------------------------------
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask

  // Data is taken just after the edge that sampled the strobe.
  task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1;
    d = rdData;
  endtask

  task automatic cmp8(input logic [7:0] exp, input logic [7:0] got);
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic cmpBit(input logic exp, input logic got);
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Every register reads zero out of reset, an unmapped one too.
  task automatic testReset();
    logic [7:0] v;
    for (int i = 0; i < 8; i++)
    begin
      rdReg(8'(i), v);
      cmp8(8'h00, v);
    end
    cmpBit(1'b0, irq);
    $display("test reset done");
  endtask

  // Stopped timer keeps its value; undivided one steps by one per cycle, divide by 8 once per eight.
  task automatic testCount();
    logic [7:0] v1;
    logic [7:0] v2;
    wrReg(OFF_COUNT, 8'h10);
    repeat (20) @(posedge clk);
    rdReg(OFF_COUNT, v1);
    cmp8(8'h10, v1);
    wrReg(OFF_CONTROL, 8'h01);
    @(posedge clk);
    addr <= OFF_COUNT;
    rdStrobe <= 1'b1;
    @(posedge clk);
    #1 v1 = rdData;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 v2 = rdData;
    cmp8(8'h11, v1);
    cmp8(8'h12, v2);
    wrReg(OFF_CONTROL, 8'h00);
    // An async register write restarts the prescaler, so divide by 8 ticks at 8, 16 and 24.
    wrReg(OFF_ASYNC, 8'h00);
    wrReg(OFF_COUNT, 8'h00);
    wrReg(OFF_CONTROL, 8'h02);
    repeat (20) @(posedge clk);
    wrReg(OFF_CONTROL, 8'h00);
    rdReg(OFF_COUNT, v1);
    cmp8(8'h03, v1);
    $display("test count done");
  endtask

  // Wrap from all ones sets the overflow flag, masked and cleared in turn.
  task automatic testOverflow();
    logic [7:0] v;
    wrReg(OFF_FLAG_CLR, 8'h03);
    wrReg(OFF_MASK, 8'h01);
    wrReg(OFF_COUNT, 8'hFE);
    wrReg(OFF_CONTROL, 8'h01);
    repeat (4) @(posedge clk);
    wrReg(OFF_CONTROL, 8'h00);
    rdReg(OFF_COUNT, v);
    cmp8(8'h04, v);
    rdReg(OFF_FLAG, v);
    cmpBit(1'b1, v[FLAG_OVF_BIT]);
    cmpBit(1'b1, irq);
    wrReg(OFF_MASK, 8'h00);
    #1 cmpBit(1'b0, irq);
    wrReg(OFF_MASK, 8'h01);
    wrReg(OFF_FLAG_CLR, 8'h01);
    #1 cmpBit(1'b0, irq);
    $display("test overflow done");
  endtask

  // Clear-on-compare keeps the count at or below the compare value.
  task automatic testCtc();
    logic [7:0] v;
    wrReg(OFF_FLAG_CLR, 8'h03);
    wrReg(OFF_MASK, 8'h02);
    wrReg(OFF_COMPARE, 8'h05);
    wrReg(OFF_COUNT, 8'h00);
    wrReg(OFF_CONTROL, 8'h11);
    repeat (30) @(posedge clk);
    wrReg(OFF_CONTROL, 8'h00);
    rdReg(OFF_COUNT, v);
    cmp8(8'h02, v);
    rdReg(OFF_FLAG, v);
    cmpBit(1'b1, v[FLAG_CMP_BIT]);
    cmpBit(1'b0, v[FLAG_OVF_BIT]);
    cmpBit(1'b1, irq);
    wrReg(OFF_FLAG_CLR, 8'h02);
    #1 cmpBit(1'b0, irq);
    $display("test ctc done");
  endtask

  // With the async select set only crystal edges advance the count.
  task automatic testAsync();
    logic [7:0] v;
    wrReg(OFF_ASYNC, 8'h01);
    wrReg(OFF_COUNT, 8'h00);
    wrReg(OFF_CONTROL, 8'h01);
    repeat (20) @(posedge clk);
    rdReg(OFF_COUNT, v);
    cmp8(8'h00, v);
    rdReg(OFF_ASYNC, v);
    cmp8(8'h01, v);
    @(posedge clk);
    repeat (10)
    begin
      crystalIn <= 1'b1;
      repeat (3) @(posedge clk);
      cmpBit(1'b0, crystalOut);
      crystalIn <= 1'b0;
      repeat (3) @(posedge clk);
      cmpBit(1'b1, crystalOut);
    end
    wrReg(OFF_CONTROL, 8'h00);
    rdReg(OFF_COUNT, v);
    cmp8(8'h0A, v);
    wrReg(OFF_ASYNC, 8'h00);
    $display("test async done");
  endtask

  // Fast PWM high time follows the compare value; force sets, then toggles, the pin.
  task automatic testWave();
    int high;
    high = 0;
    wrReg(OFF_COMPARE, 8'h80);
    wrReg(OFF_COUNT, 8'h00);
    wrReg(OFF_CONTROL, 8'h59);
    #1 cmpBit(1'b1, cmpOutEn);
    repeat (300) @(posedge clk);
    repeat (256)
    begin
      @(posedge clk);
      #1 if (cmpPin === 1'b1) high++;
    end
    cmp8(8'h81, 8'(high));
    wrReg(OFF_CONTROL, 8'h60);
    wrReg(OFF_CONTROL, 8'hE0);
    @(posedge clk);
    #1 cmpBit(1'b1, cmpPin);
    wrReg(OFF_CONTROL, 8'h20);
    wrReg(OFF_CONTROL, 8'hA0);
    @(posedge clk);
    #1 cmpBit(1'b0, cmpPin);
    wrReg(OFF_CONTROL, 8'h00);
    #1 cmpBit(1'b0, cmpOutEn);
    $display("test wave done");
  endtask

  // Phase correct mode turns down at the top silently and flags overflow at bottom.
  task automatic testPhase();
    logic [7:0] v;
    wrReg(OFF_COUNT, 8'hFC);
    wrReg(OFF_FLAG_CLR, 8'h03);
    wrReg(OFF_CONTROL, 8'h09);
    repeat (6) @(posedge clk);
    wrReg(OFF_CONTROL, 8'h08);
    rdReg(OFF_COUNT, v);
    cmp8(8'hFA, v);
    rdReg(OFF_FLAG, v);
    cmp8(8'h00, v);
    wrReg(OFF_COUNT, 8'h02);
    wrReg(OFF_CONTROL, 8'h09);
    repeat (2) @(posedge clk);
    wrReg(OFF_CONTROL, 8'h08);
    rdReg(OFF_COUNT, v);
    cmp8(8'h02, v);
    rdReg(OFF_FLAG, v);
    cmp8(8'h01, v);
    wrReg(OFF_CONTROL, 8'h00);
    $display("test phase done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    n_fail = 0;
    n_compared = 0;
    rst_n = 1'b0;
    addr = 8'h00;
    wrData = 8'h00;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    crystalIn = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    testReset();
    testCount();
    testOverflow();
    testCtc();
    testAsync();
    testWave();
    testPhase();
    results();
  end
endmodule
`default_nettype wire
